// ### core/picture_adjust_pkg.sv
/*
 * picture_adjust_pkg: register offsets, reset values, field positions and the
 * stream sample type of the picture adjustment block.
 * Assumes byte-wide host registers addressed by an 8-bit register index.
 */
package picture_adjust_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] MISC_CTRL_OFFS  = 8'h0B;
   localparam logic [7:0] LUMA_GAIN_OFFS  = 8'h0C;
   localparam logic [7:0] U_GAIN_OFFS     = 8'h0D;
   localparam logic [7:0] V_GAIN_OFFS     = 8'h0E;
   localparam logic [7:0] PHASE_OFFS      = 8'h0F;
   localparam logic [7:0] LOOP_CTRL_OFFS  = 8'h10;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MISC_CTRL_RST   = 8'h20;
   localparam logic [7:0] LUMA_GAIN_RST   = 8'hD8;
   localparam logic [7:0] U_GAIN_RST      = 8'hFE;
   localparam logic [7:0] V_GAIN_RST      = 8'hB4;
   localparam logic [7:0] PHASE_RST       = 8'h00;
   localparam logic [7:0] LOOP_CTRL_RST   = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int V_TOP_BIT     = 0;
   localparam int U_TOP_BIT     = 1;
   localparam int LUMA_TOP_BIT  = 2;
   localparam int MISC_RSVD_BIT = 3;
   localparam int LUMA_DECIMATION_DISABLE_BIT      = 5;
   localparam int FSEL_LSB      = 3;
   localparam int COLOUR_KILL_ENABLE_BIT     = 5;
   localparam int CHROMA_AGC_ENABLE_BIT      = 6;
   localparam int PEAK_BIT      = 7;
   localparam logic [7:0] LOOP_CTRL_MASK = 8'hF8;
   localparam logic [7:0] MISC_CTRL_MASK = 8'hF7;

   // ----------------------------------------------------------------
   // gain figures
   // ----------------------------------------------------------------
   localparam int LUMA_UNITY = 216;
   localparam int U_UNITY    = 254;
   localparam int V_UNITY    = 180;
   localparam logic [7:0] AGC_MIN = 8'h20;  // 0.5 in 1/64 units
   localparam logic [7:0] AGC_MAX = 8'h80;  // 2.0 in 1/64 units
   localparam int AGC_FRAC = 6;

   // horizontal reduction thresholds, 4.4 fixed point source/output
   localparam logic [7:0] RATIO_HALF    = 8'h20;
   localparam logic [7:0] RATIO_THIRD   = 8'h30;
   localparam logic [7:0] RATIO_SEVENTH = 8'h70;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FILT_NONE  = 3'b000,
      FILT_CIF   = 3'b001,
      FILT_QCIF  = 3'b010,
      FILT_ICON  = 3'b011,
      PEAK_MAX   = 3'b100,
      PEAK_MED   = 3'b101,
      PEAK_LOW   = 3'b110,
      PEAK_MIN   = 3'b111
   } filter_mode_t;

   typedef struct packed {
      logic [7:0] luma;
      logic [7:0] u;
      logic [7:0] v;
   } sample_t;

endpackage

// ### core/sat_gain.sv
/*
 * sat_gain: one registered gain stage, out = in * gain / UNITY, saturated.
 * Assumes gain and data on clk_sys; one cycle of latency.
 */
`timescale 1ns/1ps
`default_nettype none
module sat_gain #(
   parameter int UNITY       = 216,
   parameter bit SIGNED_DATA = 1'b0
) (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic [7:0] din,
   input  wire logic [8:0] gain,
   output var  logic [7:0] dout
);
   // reciprocal with 18 fraction bits avoids a real divider
   localparam int RECIP = ((1 << 18) + UNITY / 2) / UNITY;

   logic signed [31:0] ext_w;
   logic signed [31:0] prod_w;
   logic signed [31:0] scaled_w;
   logic [7:0]         sat_w;

   assign ext_w    = SIGNED_DATA ? $signed({{24{din[7]}}, din}) : $signed({24'h000000, din});
   assign prod_w   = ext_w * $signed({23'h000000, gain}) * RECIP;
   assign scaled_w = (prod_w + 32'sh0002_0000) >>> 18;
   // clip instead of wrapping
   assign sat_w = SIGNED_DATA ?
                  ((scaled_w > 32'sd127) ? 8'h7F :
                   (scaled_w < -32'sd128) ? 8'h80 : scaled_w[7:0]) :
                  ((scaled_w > 32'sd255) ? 8'hFF :
                   (scaled_w < 32'sd0) ? 8'h00 : scaled_w[7:0]);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         dout <= 8'h00;
      else
         dout <= sat_w;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_unity_pass;
      @(posedge clk_sys) disable iff (!resetn)
      (gain == 9'(UNITY)) |=> (dout == $past(din));
   endproperty
   a_unity_pass: assert property (p_unity_pass) else $error("unity gain altered sample");

   property p_zero_gain;
      @(posedge clk_sys) disable iff (!resetn)
      (gain == 9'h000) |=> (dout == 8'h00);
   endproperty
   a_zero_gain: assert property (p_zero_gain) else $error("zero gain gave nonzero sample");

endmodule
`default_nettype wire

// ### core/picture_adjust.sv
/*
 * picture_adjust: picture adjustment registers and their datapath effects
 * (luma gain, U/V gain, hue phase offset, loop control).
 * Assumes host register strobes and the sample stream are on clk_sys.
 */
// What this block does
// - luma gain low byte resets to 0xD8, host reads and writes freely.
// - 9-bit luma gain is misc control top bit joined with low byte.
// - luma sample times gain; 216 unity, 0 zero, 511 about 236.57 percent.
// - U gain low byte resets to 0xFE, host reads and writes freely.
// - U scaled by 9-bit gain; 254 unity, 511 about 201.18 percent.
// - V gain low byte resets 0xB4; 180 unity, 511 about 283.89 percent.
// - signed hue adds to demodulation phase, 0.7 degree steps, resets zero.
// - peaking select 0 gives low-pass filtering, 1 gives peaking.
// - chroma AGC enable multiplies chroma by 0.5 to 2.0; off at reset.
// - low colour removal works only when colour kill enable is set.
// - without peaking, filter select: 00 auto, 01 CIF, 10 QCIF, 11 ICON.
// - auto: none to half, CIF to third, QCIF to seventh, then ICON.
// - with peaking, filter select gives maximum, medium, low, minimum peaking.
// - misc control holds luma top bit 2, U top bit 1, V top bit 0.
// - decimation disable 0 enables filtered decimation; 1 (default) disables.
`timescale 1ns/1ps
`default_nettype none
module picture_adjust (
   input  wire logic                            clk_sys,
   input  wire logic                            resetn,
   input  wire logic [7:0]                      reg_addr,
   input  wire logic [7:0]                      reg_wdata,
   input  wire logic                            reg_we,
   input  wire logic                            reg_re,
   output var  logic [7:0]                      reg_rdata,
   input  wire picture_adjust_pkg::sample_t     sample_in,
   input  wire logic                            sample_in_valid,
   input  wire logic [7:0]                      agc_factor,
   input  wire logic                            low_colour,
   input  wire logic [7:0]                      h_ratio,
   input  wire logic [9:0]                      sc_phase,
   output var  picture_adjust_pkg::sample_t     sample_out,
   output var  logic                            sample_out_valid,
   output var  logic [9:0]                      demod_phase,
   output var  picture_adjust_pkg::filter_mode_t filter_mode,
   output var  logic                            decimation_on,
   output var  logic                            peaking_on,
   output var  logic                            chroma_agc_enable,
   output var  logic                            colour_kill_enable
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] misc_ctrl_q;
   logic [7:0] luma_gain_low_byte_q;
   logic [7:0] u_gain_low_byte_q;
   logic [7:0] v_gain_low_byte_q;
   logic [7:0] phase_q;
   logic [7:0] loop_control_q;

   wire wr_misc  = reg_we && (reg_addr == picture_adjust_pkg::MISC_CTRL_OFFS);
   wire wr_luma  = reg_we && (reg_addr == picture_adjust_pkg::LUMA_GAIN_OFFS);
   wire wr_u     = reg_we && (reg_addr == picture_adjust_pkg::U_GAIN_OFFS);
   wire wr_v     = reg_we && (reg_addr == picture_adjust_pkg::V_GAIN_OFFS);
   wire wr_phase = reg_we && (reg_addr == picture_adjust_pkg::PHASE_OFFS);
   wire wr_loop  = reg_we && (reg_addr == picture_adjust_pkg::LOOP_CTRL_OFFS);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         misc_ctrl_q          <= picture_adjust_pkg::MISC_CTRL_RST;
         luma_gain_low_byte_q <= picture_adjust_pkg::LUMA_GAIN_RST;
         u_gain_low_byte_q    <= picture_adjust_pkg::U_GAIN_RST;
         v_gain_low_byte_q    <= picture_adjust_pkg::V_GAIN_RST;
         phase_q              <= picture_adjust_pkg::PHASE_RST;
         loop_control_q       <= picture_adjust_pkg::LOOP_CTRL_RST;
      end
      else
      begin
         if (wr_misc)
            misc_ctrl_q <= reg_wdata & picture_adjust_pkg::MISC_CTRL_MASK;
         if (wr_luma)
            luma_gain_low_byte_q <= reg_wdata;
         if (wr_u)
            u_gain_low_byte_q <= reg_wdata;
         if (wr_v)
            v_gain_low_byte_q <= reg_wdata;
         if (wr_phase)
            phase_q <= reg_wdata;
         // reserved low bits kept at zero whatever is written
         if (wr_loop)
            loop_control_q <= reg_wdata & picture_adjust_pkg::LOOP_CTRL_MASK;
      end
   end

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   logic [7:0] rd_mux_w;
   assign rd_mux_w =
      (reg_addr == picture_adjust_pkg::MISC_CTRL_OFFS) ? misc_ctrl_q :
      (reg_addr == picture_adjust_pkg::LUMA_GAIN_OFFS) ? luma_gain_low_byte_q :
      (reg_addr == picture_adjust_pkg::U_GAIN_OFFS)    ? u_gain_low_byte_q :
      (reg_addr == picture_adjust_pkg::V_GAIN_OFFS)    ? v_gain_low_byte_q :
      (reg_addr == picture_adjust_pkg::PHASE_OFFS)     ? phase_q :
      (reg_addr == picture_adjust_pkg::LOOP_CTRL_OFFS) ? loop_control_q : 8'h00;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 8'h00;
      else if (reg_re)
         reg_rdata <= rd_mux_w;
   end

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   logic [8:0] luma_gain;
   logic [8:0] u_gain;
   logic [8:0] v_gain;
   assign luma_gain = {misc_ctrl_q[picture_adjust_pkg::LUMA_TOP_BIT],
                       luma_gain_low_byte_q};
   assign u_gain    = {misc_ctrl_q[picture_adjust_pkg::U_TOP_BIT], u_gain_low_byte_q};
   assign v_gain    = {misc_ctrl_q[picture_adjust_pkg::V_TOP_BIT], v_gain_low_byte_q};

   wire       peak_sel  = loop_control_q[picture_adjust_pkg::PEAK_BIT];
   wire       agc_sel   = loop_control_q[picture_adjust_pkg::CHROMA_AGC_ENABLE_BIT];
   wire       kill_sel  = loop_control_q[picture_adjust_pkg::COLOUR_KILL_ENABLE_BIT];
   wire [1:0] fsel      = loop_control_q[picture_adjust_pkg::FSEL_LSB +: 2];
   wire       luma_decimation_disable_off  = misc_ctrl_q[picture_adjust_pkg::LUMA_DECIMATION_DISABLE_BIT];

   // ----------------------------------------------------------------
   // filter selection
   // ----------------------------------------------------------------
   picture_adjust_pkg::filter_mode_t auto_mode_w;
   picture_adjust_pkg::filter_mode_t mode_d;

   assign auto_mode_w =
      (h_ratio <= picture_adjust_pkg::RATIO_HALF)    ? picture_adjust_pkg::FILT_NONE :
      (h_ratio <= picture_adjust_pkg::RATIO_THIRD)   ? picture_adjust_pkg::FILT_CIF :
      (h_ratio <= picture_adjust_pkg::RATIO_SEVENTH) ? picture_adjust_pkg::FILT_QCIF :
                                                       picture_adjust_pkg::FILT_ICON;

   // SECAM needs the QCIF setting from software; not detected here
   assign mode_d =
      luma_decimation_disable_off ? picture_adjust_pkg::FILT_NONE :
      peak_sel ? picture_adjust_pkg::filter_mode_t'({1'b1, fsel}) :
      (fsel == 2'b00) ? auto_mode_w :
      picture_adjust_pkg::filter_mode_t'({1'b0, fsel});

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         filter_mode        <= picture_adjust_pkg::FILT_NONE;
         decimation_on      <= 1'b0;
         peaking_on         <= 1'b0;
         chroma_agc_enable  <= 1'b0;
         colour_kill_enable <= 1'b0;
         demod_phase        <= 10'h000;
      end
      else
      begin
         filter_mode        <= mode_d;
         decimation_on      <= !luma_decimation_disable_off;
         peaking_on         <= peak_sel && !luma_decimation_disable_off;
         chroma_agc_enable  <= agc_sel;
         colour_kill_enable <= kill_sel;
         demod_phase        <= sc_phase + {{2{phase_q[7]}}, phase_q};
      end
   end

   // ----------------------------------------------------------------
   // chroma agc and colour kill stage
   // ----------------------------------------------------------------
   logic [7:0]         agc_clip_w;
   logic signed [17:0] u_agc_w;
   logic signed [17:0] v_agc_w;
   picture_adjust_pkg::sample_t stage_q;
   logic                        stage_valid_q;

   function automatic logic [7:0] sat8s(input logic signed [17:0] x);
      if (x > 18'sd127)
         sat8s = 8'h7F;
      else if (x < -18'sd128)
         sat8s = 8'h80;
      else
         sat8s = x[7:0];
   endfunction

   assign agc_clip_w = (agc_factor < picture_adjust_pkg::AGC_MIN) ? picture_adjust_pkg::AGC_MIN :
                       (agc_factor > picture_adjust_pkg::AGC_MAX) ? picture_adjust_pkg::AGC_MAX :
                       agc_factor;
   assign u_agc_w = ($signed(sample_in.u) * $signed({1'b0, agc_clip_w})) >>>
                    picture_adjust_pkg::AGC_FRAC;
   assign v_agc_w = ($signed(sample_in.v) * $signed({1'b0, agc_clip_w})) >>>
                    picture_adjust_pkg::AGC_FRAC;

   wire kill_now = kill_sel && low_colour;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         stage_q       <= '0;
         stage_valid_q <= 1'b0;
      end
      else
      begin
         stage_valid_q <= sample_in_valid;
         stage_q.luma  <= sample_in.luma;
         stage_q.u     <= kill_now ? 8'h00 : agc_sel ? sat8s(u_agc_w) : sample_in.u;
         stage_q.v     <= kill_now ? 8'h00 : agc_sel ? sat8s(v_agc_w) : sample_in.v;
      end
   end

   // ----------------------------------------------------------------
   // gain stage
   // ----------------------------------------------------------------
   // U and V gains are independent; keeping their ratio is software's job
   sat_gain #(.UNITY(picture_adjust_pkg::LUMA_UNITY), .SIGNED_DATA(1'b0)) luma_gain_stage (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (stage_q.luma),
      .gain    (luma_gain),
      .dout    (sample_out.luma)
   );

   sat_gain #(.UNITY(picture_adjust_pkg::U_UNITY), .SIGNED_DATA(1'b1)) u_gain_stage (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (stage_q.u),
      .gain    (u_gain),
      .dout    (sample_out.u)
   );

   sat_gain #(.UNITY(picture_adjust_pkg::V_UNITY), .SIGNED_DATA(1'b1)) v_gain_stage (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (stage_q.v),
      .gain    (v_gain),
      .dout    (sample_out.v)
   );

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         sample_out_valid <= 1'b0;
      else
         sample_out_valid <= stage_valid_q;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_luma_read;
      @(posedge clk_sys) disable iff (!resetn)
      (reg_re && reg_addr == picture_adjust_pkg::LUMA_GAIN_OFFS) |=>
         (reg_rdata == $past(luma_gain_low_byte_q));
   endproperty
   a_luma_read: assert property (p_luma_read) else $error("luma gain readback wrong");

   property p_luma_top;
      @(posedge clk_sys) disable iff (!resetn)
      wr_misc |=> (luma_gain[8] == $past(reg_wdata[2])) && (u_gain[8] == $past(reg_wdata[1]));
   endproperty
   a_luma_top: assert property (p_luma_top) else $error("gain top bit not taken");

   property p_u_unity;
      @(posedge clk_sys) disable iff (!resetn)
      (u_gain == 9'd254 && $stable(u_gain)) |=> (sample_out.u == $past(stage_q.u));
   endproperty
   a_u_unity: assert property (p_u_unity) else $error("U unity gain altered sample");

   property p_v_unity;
      @(posedge clk_sys) disable iff (!resetn)
      (v_gain == 9'd180) |=> (sample_out.v == $past(stage_q.v));
   endproperty
   a_v_unity: assert property (p_v_unity) else $error("V unity gain altered sample");

   property p_phase;
      @(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> (demod_phase == 10'($past(sc_phase) + {{2{$past(phase_q[7])}}, $past(phase_q)}));
   endproperty
   a_phase: assert property (p_phase) else $error("phase offset wrong");

   property p_peak;
      @(posedge clk_sys) disable iff (!resetn)
      (peak_sel && !luma_decimation_disable_off) |=> peaking_on && filter_mode[2];
   endproperty
   a_peak: assert property (p_peak) else $error("peaking not selected");

   property p_kill;
      @(posedge clk_sys) disable iff (!resetn)
      (kill_sel && low_colour && sample_in_valid) |=> ##1
         (sample_out_valid && sample_out.u == 8'h00 && sample_out.v == 8'h00);
   endproperty
   a_kill: assert property (p_kill) else $error("colour not removed");

   property p_auto;
      @(posedge clk_sys) disable iff (!resetn)
      (!luma_decimation_disable_off && !peak_sel && fsel == 2'b00 && h_ratio > picture_adjust_pkg::RATIO_SEVENTH)
         |=> (filter_mode == picture_adjust_pkg::FILT_ICON);
   endproperty
   a_auto: assert property (p_auto) else $error("auto filter choice wrong");

   property p_luma_decimation_disable;
      @(posedge clk_sys) disable iff (!resetn)
      luma_decimation_disable_off |=> !decimation_on && (filter_mode == picture_adjust_pkg::FILT_NONE);
   endproperty
   a_luma_decimation_disable: assert property (p_luma_decimation_disable) else $error("decimation active while disabled");

   property p_lat;
      @(posedge clk_sys) disable iff (!resetn)
      sample_in_valid |-> ##2 sample_out_valid;
   endproperty
   a_lat: assert property (p_lat) else $error("sample latency not two");

   c_peak:  cover property (@(posedge clk_sys) disable iff (!resetn) peaking_on);
   c_kill:  cover property (@(posedge clk_sys) disable iff (!resetn) kill_now && sample_in_valid);
   c_agc:   cover property (@(posedge clk_sys) disable iff (!resetn) agc_sel && sample_in_valid);
   c_qcif:  cover property (@(posedge clk_sys) disable iff (!resetn)
                            filter_mode == picture_adjust_pkg::FILT_QCIF);

endmodule
`default_nettype wire

// ### dv/tb_top.sv
/* tb_top: self-checking bench for picture_adjust; registers, sample stream, controls.
   Assumes the design package and modules are compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                             clk_sys = 1'b0;
   logic                             resetn = 1'b0;
   logic [7:0]                       reg_addr = 8'h00;
   logic [7:0]                       reg_wdata = 8'h00;
   logic                             reg_we = 1'b0;
   logic                             reg_re = 1'b0;
   logic [7:0]                       reg_rdata;
   picture_adjust_pkg::sample_t      sample_in = '0;
   logic                             sample_in_valid = 1'b0;
   logic [7:0]                       agc_factor = 8'h40;
   logic                             low_colour = 1'b0;
   logic [7:0]                       h_ratio = 8'h10;
   logic [9:0]                       sc_phase = 10'h000;
   picture_adjust_pkg::sample_t      sample_out;
   logic                             sample_out_valid;
   logic [9:0]                       demod_phase;
   picture_adjust_pkg::filter_mode_t filter_mode;
   logic                             decimation_on;
   logic                             peaking_on;
   logic                             chroma_agc_enable;
   logic                             colour_kill_enable;
   int                               seed = 15351;
   int                               errors = 0;
   int                               n_tests = 0;
   int                               q [$];
   logic [7:0]                       hr [6] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h70, 8'h71};
   logic [7:0]                       m [int] = '{8'h0B: 8'h20, 8'h0C: 8'hD8, 8'h0D: 8'hFE,
                                                 8'h0E: 8'hB4, 8'h0F: 8'h00, 8'h10: 8'h00};

   always #20 clk_sys = ~clk_sys;

   picture_adjust dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .sample_in(sample_in), .sample_in_valid(sample_in_valid), .agc_factor(agc_factor),
      .low_colour(low_colour), .h_ratio(h_ratio), .sc_phase(sc_phase),
      .sample_out(sample_out), .sample_out_valid(sample_out_valid),
      .demod_phase(demod_phase), .filter_mode(filter_mode), .decimation_on(decimation_on),
      .peaking_on(peaking_on), .chroma_agc_enable(chroma_agc_enable),
      .colour_kill_enable(colour_kill_enable));

   // ----------------------------------------------------------------
   // model and checking
   // ----------------------------------------------------------------
   task automatic chk(input logic [9:0] got, input int exp, input int tol, input bit sg);
      int g;
      g = sg ? int'($signed(got[7:0])) : int'(got);
      n_tests++;
      if ((^got === 1'bx) || (g - exp > tol) || (exp - g > tol))
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp[9:0]);
      end
   endtask

   // rounding of the gain stage is left open, so one step of slack
   function automatic int gn(input int x, input int g, input int un, input int lo, input int hi);
      int r;
      r = (x * g + (x < 0 ? -un / 2 : un / 2)) / un;
      return r < lo ? lo : (r > hi ? hi : r);
   endfunction

   function automatic int ch(input int x, input int g, input int un);
      int a;
      a = agc_factor < 8'h20 ? 32 : (agc_factor > 8'h80 ? 128 : int'(agc_factor));
      if (m[8'h10][5] && low_colour)
         x = 0;
      else if (m[8'h10][6])
         x = gn((x * a) >>> 6, 1, 1, -128, 127);
      return gn(x, g, un, -128, 127);
   endfunction

   always @(negedge clk_sys)
      if (sample_out_valid === 1'b1)
      begin
         if (q.size() < 3)
            chk(10'h3FF, 0, 0, 0);
         else
         begin
            chk(sample_out.luma, q.pop_front(), 1, 0);
            chk(sample_out.u, q.pop_front(), 1, 1);
            chk(sample_out.v, q.pop_front(), 1, 1);
         end
      end

   task automatic print_verdict();
      $display("TB: errors=%0d checks=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk_sys);
      reg_we <= 1'b0;
      if (m.exists(a))
         m[a] = d & (a == 8'h10 ? 8'hF8 : (a == 8'h0B ? 8'hF7 : 8'hFF));
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clk_sys);
      reg_re <= 1'b0;
      #1;
      chk(reg_rdata, m.exists(a) ? int'(m[a]) : 0, 0, 0);
   endtask

   task automatic ctl();
      logic [2:0] f;
      repeat (2) @(posedge clk_sys);
      #1;
      f = m[8'h0B][5] ? 3'b000 : m[8'h10][7] ? {1'b1, m[8'h10][4:3]} :
          m[8'h10][4:3] != 2'b00 ? {1'b0, m[8'h10][4:3]} : h_ratio <= 8'h20 ? 3'b000 :
          h_ratio <= 8'h30 ? 3'b001 : h_ratio <= 8'h70 ? 3'b010 : 3'b011;
      chk(filter_mode, f, 0, 0);
      chk({decimation_on, peaking_on, chroma_agc_enable, colour_kill_enable},
          {~m[8'h0B][5], m[8'h10][7] & ~m[8'h0B][5], m[8'h10][6:5]}, 0, 0);
   endtask

   task automatic stream(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         sample_in <= 24'($random(seed));
         sample_in_valid <= 1'($random(seed));
         #1;
         if (sample_in_valid)
         begin
            q.push_back(gn(sample_in.luma, {m[8'h0B][2], m[8'h0C]}, 216, 0, 255));
            q.push_back(ch($signed(sample_in.u), {m[8'h0B][1], m[8'h0D]}, 254));
            q.push_back(ch($signed(sample_in.v), {m[8'h0B][0], m[8'h0E]}, 180));
         end
      end
      @(posedge clk_sys);
      sample_in_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask

   initial
   begin
      #2000000;
      errors++;
      print_verdict();
   end

   initial
   begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      foreach (m[a]) rd(8'(a));
      rd(8'h11);
      ctl();
      stream(20);
      for (int a = 8'h0B; a <= 8'h11; a++)
      begin
         wr(8'(a), 8'($random(seed)));
         rd(8'(a));
      end
      for (int i = 0; i < 6; i++)
      begin
         agc_factor <= 8'($random(seed));
         low_colour <= (i == 3) | 1'($random(seed));
         wr(8'h0B, i == 0 ? 8'h07 : (i == 1 ? 8'h00 : 8'($random(seed)) & 8'hF7));
         for (int a = 8'h0C; a <= 8'h0E; a++)
            wr(8'(a), i == 0 ? 8'hFF : (i == 1 ? 8'h00 : 8'($random(seed))));
         wr(8'h10, i == 2 ? 8'h40 : (i == 3 ? 8'h20 : 8'($random(seed)) & 8'hF8));
         ctl();
         stream(16);
      end
      foreach (hr[i])
      begin
         wr(8'h0F, i == 0 ? 8'h80 : (i == 1 ? 8'h7F : 8'($random(seed))));
         sc_phase <= 10'($random(seed));
         repeat (2) @(posedge clk_sys);
         #1;
         chk(demod_phase, (int'(sc_phase) + int'($signed(m[8'h0F]))) & 1023, 0, 0);
      end
      for (int k = 0; k < 16; k++)
      begin
         wr(8'h0B, (m[8'h0B] & 8'hD7) | (k[3] ? 8'h20 : 8'h00));
         wr(8'h10, {k[2], 2'b00, k[1:0], 3'b000});
         foreach (hr[j])
         begin
            h_ratio <= hr[j];
            ctl();
         end
      end
      chk(10'(q.size()), 0, 0, 0);
      print_verdict();
   end
endmodule
`default_nettype wire
